// ===== design/cps_params.svh
// Purpose: constants for the charge path sequencer
// Assumes: 20 MHz core clock (50 ns period)
// Notes:   times kept in their own unit, cycle counts derived
`ifndef CPS_PARAMS_SVH
`define CPS_PARAMS_SVH

// ----------------------------------------------------------------
// clock and times
// ----------------------------------------------------------------
`define CPS_CLK_NS 50
`define CPS_POWERUP_MS 30
`define CPS_SLEEP_EXIT_MS 30
`define CPS_DEAD_PATH_US 10
`define CPS_SS_STEP_US 1600
`define CPS_SS_STEPS 8
`define CPS_DEAD_CONV_NS 30
`define CPS_REFRESH_NS 80
`define CPS_BOOT_LOW_CYCLES 3
`define CPS_DIE_OVERTEMP_STOP_RISE_C 145
`define CPS_DIE_OVERTEMP_STOP_HYST_C 15

// least times round up, none under one cycle
`define CPS_POWERUP_CYC ((`CPS_POWERUP_MS*1000000+`CPS_CLK_NS-1)/`CPS_CLK_NS)
`define CPS_SLEEP_EXIT_CYC \
  ((`CPS_SLEEP_EXIT_MS*1000000+`CPS_CLK_NS-1)/`CPS_CLK_NS)
`define CPS_DEAD_PATH_CYC ((`CPS_DEAD_PATH_US*1000+`CPS_CLK_NS-1)/`CPS_CLK_NS)
`define CPS_SS_STEP_CYC ((`CPS_SS_STEP_US*1000+`CPS_CLK_NS-1)/`CPS_CLK_NS)
`define CPS_DEAD_CONV_CYC ((`CPS_DEAD_CONV_NS+`CPS_CLK_NS-1)/`CPS_CLK_NS)
`define CPS_REFRESH_CYC ((`CPS_REFRESH_NS+`CPS_CLK_NS-1)/`CPS_CLK_NS)

`endif

// ===== design/cps_pkg.sv
// Purpose: types for the charge path sequencer
// Assumes: nothing beyond the params header
// Notes:   analog comparator results arrive as one struct
package cps_pkg;

  // ----------------------------------------------------------------
  // comparator and status inputs
  // ----------------------------------------------------------------
  typedef struct packed {
    logic supplyAboveBat;   // supply above battery sense node
    logic supplyNearBat;    // supply within 200 mV above sense node
    logic underVoltage;     // undervoltage lockout
    logic lowSupply;        // low supply state
    logic inputOverVolt;    // above input overvoltage level
    logic regsGood;         // both regulators at level
    logic regsOverload;     // regulator overload
    logic tempAboveRise;    // die at or above 145 C
    logic tempBelowFall;    // die below 130 C
    logic thermFault;       // thermistor out of range
    logic safetyExpired;    // safety timer expiry
  } cps_sense_t;

  // ----------------------------------------------------------------
  // power path states
  // ----------------------------------------------------------------
  typedef enum logic [2:0] {
    PathBattery, PathSleepExit, PathDeadToAdp, PathAdapter, PathDeadToBat
  } cps_path_t;

  // converter switching mode
  typedef enum logic [1:0] {
    ModeOff, ModeSync, ModeNonSync
  } cps_mode_t;

endpackage

// ===== design/cps_soft_start.sv
// Purpose: steps the charge current reference up on charge entry
// Assumes: start is high for the whole fast charge period
// Notes:   reference drops to zero when start falls
`timescale 1ns/1ps
`include "cps_params.svh"
module cps_soft_start #(
  parameter int STEPS = `CPS_SS_STEPS,
  parameter int STEP_CYC = `CPS_SS_STEP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic start,
  // reference out, in eighths of programmed current
  output logic [3:0] refLevel
);

  initial begin
    if (STEPS < 1 || STEPS > 15 || STEP_CYC < 1 || STEP_CYC > 131072) begin
      $error("cps_soft_start: bad parameters");
    end
  end

  logic [16:0] cnt_ff;
  logic [3:0] lvl_ff;

  // ----------------------------------------------------------------
  // step timer and level
  // ----------------------------------------------------------------
  // level 1 on the first start cycle, each later step held STEP_CYC cycles, restarting on every entry
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_ff <= 17'h0_0000;
      lvl_ff <= 4'h0;
    end else if (!start) begin
      cnt_ff <= 17'h0_0000;
      lvl_ff <= 4'h0;
    end else if (lvl_ff == 4'(STEPS)) begin
      cnt_ff <= 17'h0_0000;
    end else if (cnt_ff == 17'(STEP_CYC - 1) || lvl_ff == 4'h0) begin
      cnt_ff <= 17'h0_0000;
      lvl_ff <= lvl_ff + 4'h1;
    end else begin
      cnt_ff <= cnt_ff + 17'h0_0001;
    end
  end

  assign refLevel = lvl_ff;

  AST_SS_RESTART: assert property (@(posedge clock) disable iff (reset)
    !start |=> refLevel == 4'h0) else $error("soft start not cleared");
  AST_SS_MONO: assert property (@(posedge clock) disable iff (reset)
    start && $past(start) |-> refLevel >= $past(refLevel))
    else $error("soft start fell");

endmodule

// ===== design/cps_pulse_timer.sv
// Purpose: retriggerable one-shot of a fixed length
// Assumes: trigger is a level or pulse in the core clock
// Notes:   busy high for LEN cycles after last trigger
`timescale 1ns/1ps
module cps_pulse_timer #(
  parameter int LEN = 1,
  parameter int W = 20
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // control
  input wire logic trigger,
  // status
  output logic busy,
  output logic done
);

  initial begin
    if (LEN < 1 || LEN >= (1 << W)) begin
      $error("cps_pulse_timer: LEN out of range");
    end
  end

  logic [W-1:0] cnt_ff;

  // ----------------------------------------------------------------
  // down counter, reloaded on every trigger
  // ----------------------------------------------------------------
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      cnt_ff <= '0;
    end else if (trigger) begin
      cnt_ff <= W'(LEN);
    end else if (cnt_ff != '0) begin
      cnt_ff <= cnt_ff - W'(1);
    end
  end

  assign busy = (cnt_ff != '0);
  assign done = (cnt_ff == W'(1)) && !trigger;

endmodule

// ===== design/cps_charge_path_sequencer.sv
// Purpose: power source selection, charge qualify, converter drive
// Assumes: comparators synchronous to the 20 MHz oscillator clock
// Notes:   drives are active-high "switch on" commands
`timescale 1ns/1ps
`include "cps_params.svh"
module cps_charge_path_sequencer #(
  parameter int POWERUP_CYC = `CPS_POWERUP_CYC,
  parameter int SLEEP_EXIT_CYC = `CPS_SLEEP_EXIT_CYC,
  parameter int DEAD_PATH_CYC = `CPS_DEAD_PATH_CYC,
  parameter int SS_STEP_CYC = `CPS_SS_STEP_CYC
) (
  // clock and reset
  input wire logic clock,
  input wire logic reset,
  // analog comparator results
  input wire cps_pkg::cps_sense_t sense,
  input wire logic chargeEnable,
  // converter comparator results
  input wire logic cycleStart,      // one-cycle pulse, PWM period start
  input wire logic pwmRequest,      // ramp comparison, high-side wanted
  input wire logic bootLow,         // bootstrap below 4.2 V
  input wire logic senseAboveSync,  // charge sense above 5 mV
  input wire logic senseAvgLow,     // averaged sense below 1.25 mV
  input wire logic batteryBelow2V,
  // path switch drives
  output logic adapterSwitchDrive,
  output logic batterySwitchDrive,
  // converter drives
  output logic highSideOn,
  output logic lowSideOn,
  // status
  output logic charging,
  output logic sleeping,
  output logic [3:0] chargeRef,
  output cps_pkg::cps_mode_t convMode
);

  initial begin
    if (POWERUP_CYC < 1 || SLEEP_EXIT_CYC < 1 || DEAD_PATH_CYC < 1 ||
        SS_STEP_CYC < 1 || POWERUP_CYC > 4194303 ||
        SLEEP_EXIT_CYC > 4194303 || DEAD_PATH_CYC > 4194303) begin
      $error("cps_charge_path_sequencer: bad timing parameters");
    end
  end

  // ----------------------------------------------------------------
  // declarations
  // ----------------------------------------------------------------
  cps_pkg::cps_path_t path_ff;
  cps_pkg::cps_path_t nxt_path;
  cps_pkg::cps_mode_t mode_ff;
  logic ceLast_ff;
  logic ceFall;
  logic die_overtemp_stop_ff;
  logic safetyLatch_ff;
  logic [21:0] pwrCnt_ff;
  logic pwrDone_ff;
  logic charge_ff;
  logic adp_ff;
  logic bat_ff;
  logic hs_ff;
  logic ls_ff;
  logic sleep_ff;
  logic exitBusy;
  logic exitDone;
  logic deadBusy;
  logic deadDone;
  logic refreshBusy;
  logic [1:0] bootCnt_ff;
  logic bootForce;
  logic convDead_ff;
  logic lockout;
  logic canStart;
  logic mustStop;
  logic [3:0] ssLevel;
  logic dutyCap_ff;
  logic hsWant;

  // ----------------------------------------------------------------
  // enable edge and latched faults
  // ----------------------------------------------------------------
  assign ceFall = ceLast_ff && !chargeEnable;

  // enable history
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      ceLast_ff <= 1'b0;
    end else begin
      ceLast_ff <= chargeEnable;
    end
  end

  // die overtemp stop with hysteresis, set wins over clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      die_overtemp_stop_ff <= 1'b0;
    end else if (sense.tempAboveRise) begin
      die_overtemp_stop_ff <= 1'b1;
    end else if (sense.tempBelowFall || ceFall) begin
      die_overtemp_stop_ff <= 1'b0;
    end
  end

  // safety timer fault held until enable falls; expiry wins the clear
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      safetyLatch_ff <= 1'b0;
    end else if (sense.safetyExpired) begin
      safetyLatch_ff <= 1'b1;
    end else if (ceFall) begin
      safetyLatch_ff <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // power-up delay
  // ----------------------------------------------------------------
  // counts from reset release; enable fall restarts it
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      pwrCnt_ff <= 22'h00_0000;
      pwrDone_ff <= 1'b0;
    end else if (ceFall) begin
      pwrCnt_ff <= 22'h00_0000;
      pwrDone_ff <= 1'b0;
    end else if (pwrCnt_ff == 22'(POWERUP_CYC - 1)) begin
      pwrDone_ff <= 1'b1;
    end else begin
      pwrCnt_ff <= pwrCnt_ff + 22'h00_0001;
    end
  end

  // ----------------------------------------------------------------
  // power path sequencing
  // ----------------------------------------------------------------
  assign lockout = sense.underVoltage;

  // sleep exit delay restarts whenever sleep reappears
  cps_pulse_timer #(.LEN(SLEEP_EXIT_CYC), .W(22)) u_exit (
    .clock(clock),
    .reset(reset),
    .trigger(path_ff == cps_pkg::PathBattery),
    .busy(exitBusy),
    .done(exitDone)
  );

  // break-before-make dead time for either direction
  cps_pulse_timer #(.LEN(DEAD_PATH_CYC), .W(22)) u_dead (
    .clock(clock),
    .reset(reset),
    .trigger(path_ff != nxt_path && (nxt_path == cps_pkg::PathDeadToAdp ||
             nxt_path == cps_pkg::PathDeadToBat)),
    .busy(deadBusy),
    .done(deadDone)
  );

  // next path state
  always_comb begin
    nxt_path = path_ff;
    unique case (path_ff)
      cps_pkg::PathBattery: begin
        if (sense.supplyAboveBat && !lockout && !sense.inputOverVolt) begin
          nxt_path = cps_pkg::PathSleepExit;
        end
      end
      cps_pkg::PathSleepExit: begin
        if (!sense.supplyAboveBat || lockout || sense.inputOverVolt) begin
          nxt_path = cps_pkg::PathBattery;
        end else if (exitDone) begin
          nxt_path = cps_pkg::PathDeadToAdp;
        end
      end
      cps_pkg::PathDeadToAdp: begin
        if (lockout || !sense.supplyAboveBat || sense.inputOverVolt) begin
          nxt_path = cps_pkg::PathBattery;
        end else if (deadDone) begin
          nxt_path = cps_pkg::PathAdapter;
        end
      end
      cps_pkg::PathAdapter: begin
        if (lockout || sense.inputOverVolt) begin
          nxt_path = cps_pkg::PathBattery;
        end else if (sense.supplyNearBat) begin
          nxt_path = cps_pkg::PathDeadToBat;
        end
      end
      cps_pkg::PathDeadToBat: begin
        if (lockout || deadDone) begin
          nxt_path = cps_pkg::PathBattery;
        end
      end
      default: begin
        nxt_path = cps_pkg::PathBattery;
      end
    endcase
  end

  // path state register
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      path_ff <= cps_pkg::PathBattery;
    end else begin
      path_ff <= nxt_path;
    end
  end

  // switch drives: both off in the dead states
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      adp_ff <= 1'b0;
      bat_ff <= 1'b1;
      sleep_ff <= 1'b1;
    end else begin
      adp_ff <= (nxt_path == cps_pkg::PathAdapter) && !lockout;
      bat_ff <= (nxt_path == cps_pkg::PathBattery) ||
                (nxt_path == cps_pkg::PathSleepExit);
      sleep_ff <= (nxt_path == cps_pkg::PathBattery);
    end
  end

  // ----------------------------------------------------------------
  // charge qualification
  // ----------------------------------------------------------------
  assign canStart = chargeEnable && !lockout && !sense.lowSupply &&
    path_ff == cps_pkg::PathAdapter && !sense.inputOverVolt &&
    pwrDone_ff && sense.regsGood && !die_overtemp_stop_ff && !sense.thermFault &&
    !safetyLatch_ff;
  assign mustStop = !chargeEnable || lockout || sense.lowSupply ||
    path_ff != cps_pkg::PathAdapter || sense.inputOverVolt ||
    sense.regsOverload || die_overtemp_stop_ff || sense.thermFault ||
    sense.safetyExpired || safetyLatch_ff;

  // charge run flag
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      charge_ff <= 1'b0;
    end else if (mustStop) begin
      charge_ff <= 1'b0;
    end else if (canStart) begin
      charge_ff <= 1'b1;
    end
  end

  // soft-start of the current reference
  cps_soft_start #(.STEPS(`CPS_SS_STEPS), .STEP_CYC(SS_STEP_CYC)) u_ss (
    .clock(clock),
    .reset(reset),
    .start(charge_ff),
    .refLevel(ssLevel)
  );

  // ----------------------------------------------------------------
  // converter switching
  // ----------------------------------------------------------------
  // mode select
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      mode_ff <= cps_pkg::ModeOff;
    end else if (!charge_ff) begin
      mode_ff <= cps_pkg::ModeOff;
    end else if (senseAboveSync && !batteryBelow2V && !senseAvgLow) begin
      mode_ff <= cps_pkg::ModeSync;
    end else begin
      mode_ff <= cps_pkg::ModeNonSync;
    end
  end

  // bootstrap low cycle count, restarted when bootstrap recovers
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      bootCnt_ff <= 2'h0;
    end else if (!bootLow || refreshBusy) begin
      bootCnt_ff <= 2'h0;
    end else if (cycleStart && bootCnt_ff != 2'h3) begin
      bootCnt_ff <= bootCnt_ff + 2'h1;
    end
  end

  assign bootForce = bootLow && cycleStart &&
    (bootCnt_ff == 2'(`CPS_BOOT_LOW_CYCLES));

  // two-cycle (100 ns) refresh pulse on forced refresh or low bootstrap in DCM
  cps_pulse_timer #(.LEN(`CPS_REFRESH_CYC), .W(4)) u_ref (
    .clock(clock),
    .reset(reset),
    .trigger(!refreshBusy && mode_ff != cps_pkg::ModeOff &&
             (bootForce || (mode_ff == cps_pkg::ModeNonSync && bootLow &&
              !hsWant))),
    .busy(refreshBusy),
    .done()
  );

  // high-side request gated by duty cap; a net so every reader sees changes
  assign hsWant = pwmRequest && !dutyCap_ff;

  // duty cap: one cycle off at each period start
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      dutyCap_ff <= 1'b0;
    end else begin
      dutyCap_ff <= cycleStart;
    end
  end

  // dead time register for synchronous transitions
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      convDead_ff <= 1'b0;
    end else begin
      convDead_ff <= (hsWant != hs_ff);
    end
  end

  // gate drives
  always_ff @(posedge clock or posedge reset) begin
    if (reset) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
    end else if (mode_ff == cps_pkg::ModeOff) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b0;
    end else if (refreshBusy) begin
      hs_ff <= 1'b0;
      ls_ff <= 1'b1;
    end else begin
      hs_ff <= hsWant && !ls_ff;
      ls_ff <= (mode_ff == cps_pkg::ModeSync) && !hsWant &&
               !hs_ff && !convDead_ff;
    end
  end

  // ----------------------------------------------------------------
  // outputs
  // ----------------------------------------------------------------
  assign adapterSwitchDrive = adp_ff;
  assign batterySwitchDrive = bat_ff;
  assign highSideOn = hs_ff;
  assign lowSideOn = ls_ff;
  assign charging = charge_ff;
  assign sleeping = sleep_ff;
  assign chargeRef = ssLevel;
  assign convMode = mode_ff;

  // ----------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------
  AST_NO_SHOOT: assert property (@(posedge clock) disable iff (reset)
    !(adp_ff && bat_ff)) else $error("path switches both on");
  AST_DEAD_BEFORE_ADP: assert property (@(posedge clock) disable iff (reset)
    $rose(adp_ff) |-> $past(!bat_ff, 2)) else $error("no dead time");
  AST_LOCKOUT: assert property (@(posedge clock) disable iff (reset)
    lockout |=> !adp_ff && !charge_ff) else $error("lockout ignored");
  AST_SLEEP_BAT: assert property (@(posedge clock) disable iff (reset)
    sleep_ff |-> bat_ff) else $error("sleep without battery");
  AST_STOP: assert property (@(posedge clock) disable iff (reset)
    !chargeEnable |=> !charge_ff) else $error("charge not stopped");
  AST_START: assert property (@(posedge clock) disable iff (reset)
    $rose(charge_ff) |-> $past(pwrDone_ff && chargeEnable))
    else $error("charge started early");
  AST_DIE_OVERTEMP_STOP: assert property (@(posedge clock) disable iff (reset)
    sense.tempAboveRise |=> die_overtemp_stop_ff) else $error("overtemp missed");
  AST_HS_LS: assert property (@(posedge clock) disable iff (reset)
    !(hs_ff && ls_ff)) else $error("converter shoot-through");
  AST_OFF_MODE: assert property (@(posedge clock) disable iff (reset)
    mode_ff == cps_pkg::ModeOff |=> !hs_ff) else $error("hs on idle");
  AST_CE_CLEAR: assert property (@(posedge clock) disable iff (reset)
    ceFall |=> !pwrDone_ff) else $error("timer not cleared");
  // high side off in the second cycle after each period start
  AST_DUTY_CAP: assert property (
    @(posedge clock) disable iff (reset) cycleStart |-> ##2 !hs_ff)
    else $error("duty cap missing");

endmodule

// ===== verif/cps_path_model.sv
// Purpose: far-side path switches, comparators and bootstrap cap
// Assumes: node voltages in millivolts, set by the bench
// Notes:   shoot stays set once both switches of a pair are on
`timescale 1ns/1ps
module cps_path_model #(
  parameter int LEAK_CYC = 12
) (
  // clock
  input wire logic clock,
  // drives from the sequencer
  input wire logic adapterSwitchDrive,
  input wire logic batterySwitchDrive,
  input wire logic highSideOn,
  input wire logic lowSideOn,
  // node voltages
  input wire logic [15:0] supplyMv,
  input wire logic [15:0] batteryMv,
  // comparator results and fault flag
  output logic supplyAboveBat,
  output logic supplyNearBat,
  output logic bootLow,
  output logic shoot
);
  int leakCnt = 0;
  // ----------------------------------------------------------
  // comparators
  // ----------------------------------------------------------
  assign supplyAboveBat = supplyMv > batteryMv;
  assign supplyNearBat = supplyMv <= batteryMv + 16'h00c8;
  // cap leaks down until the low side pulls the switch node down
  always @(posedge clock) begin
    leakCnt <= lowSideOn ? 0 : leakCnt + 1;
  end
  assign bootLow = leakCnt > LEAK_CYC;
  // both switches of a pair on at once is a shoot-through
  initial shoot = 1'b0;
  always @(posedge clock) begin
    if ((adapterSwitchDrive && batterySwitchDrive) ||
        (highSideOn && lowSideOn)) begin
      shoot <= 1'b1;
    end
  end
endmodule

// ===== verif/tb_cps_charge_path_sequencer.sv
// Purpose: self-checking bench for the charge path sequencer
// Assumes: shortened delay parameters, 20 MHz clock
// Notes:   partner model supplies supply comparators and bootstrap
`timescale 1ns/1ps
module tb_cps_charge_path_sequencer;
  localparam int PUP = 20;
  localparam int SLX = 20;
  localparam int DEAD = 5;
  localparam int STEP = 4;
  localparam logic [2:0] MODE_IN [4] = '{3'h4, 3'h0, 3'h6, 3'h5};
  localparam logic [10:0] FAULT [5] = '{11'h080, 11'h040, 11'h100,
                                         11'h010, 11'h002};
  logic clock = 1'b0;
  logic reset = 1'b1;
  cps_pkg::cps_sense_t cfg = '0;
  cps_pkg::cps_sense_t sense;
  logic chargeEnable = 1'b0;
  logic cycleStart = 1'b0;
  logic pwmRequest = 1'b0;
  logic senseAboveSync = 1'b0;
  logic senseAvgLow = 1'b0;
  logic batteryBelow2V = 1'b0;
  logic [2:0] pcnt = 3'h0;
  logic [15:0] supplyMv = 16'h0000;
  logic [15:0] batteryMv = 16'h2ee0;
  logic above, near, bootLow, shoot, adapterDrv, batteryDrv;
  logic highSideOn, lowSideOn, charging, sleeping;
  logic [3:0] chargeRef;
  cps_pkg::cps_mode_t convMode;
  int err_total = 0;
  int check_count = 0;
  int lowRun = 0;
  int lowMax = 0;
  int lowPulses = 0;
  int highCnt = 0;
  int t, off, i, s;

  cps_charge_path_sequencer #(.POWERUP_CYC(PUP), .SLEEP_EXIT_CYC(SLX),
    .DEAD_PATH_CYC(DEAD), .SS_STEP_CYC(STEP)) DUT (
    .clock(clock), .reset(reset), .sense(sense),
    .chargeEnable(chargeEnable), .cycleStart(cycleStart),
    .pwmRequest(pwmRequest), .bootLow(bootLow),
    .senseAboveSync(senseAboveSync), .senseAvgLow(senseAvgLow),
    .batteryBelow2V(batteryBelow2V), .adapterSwitchDrive(adapterDrv),
    .batterySwitchDrive(batteryDrv), .highSideOn(highSideOn),
    .lowSideOn(lowSideOn), .charging(charging), .sleeping(sleeping),
    .chargeRef(chargeRef), .convMode(convMode));

  cps_path_model partner (
    .clock(clock), .adapterSwitchDrive(adapterDrv),
    .batterySwitchDrive(batteryDrv), .highSideOn(highSideOn),
    .lowSideOn(lowSideOn), .supplyMv(supplyMv), .batteryMv(batteryMv),
    .supplyAboveBat(above), .supplyNearBat(near), .bootLow(bootLow),
    .shoot(shoot));

  // ----------------------------------------------------------
  // clock, pwm period and monitors
  // ----------------------------------------------------------
  always #25 clock = ~clock;
  always @(posedge clock) begin
    pcnt <= pcnt + 3'h1;
    cycleStart <= pcnt == 3'h7;
  end
  // comparators from the partner merged over the bench's fields
  always_comb begin
    sense = cfg;
    sense.supplyAboveBat = above;
    sense.supplyNearBat = near;
  end
  // low-side pulse lengths and high-side on count
  always @(negedge clock) begin
    lowRun = lowSideOn ? lowRun + 1 : 0;
    if (lowRun > lowMax) lowMax = lowRun;
    if (lowRun == 1) lowPulses++;
    if (highSideOn) highCnt++;
  end

  // ----------------------------------------------------------
  // tasks
  // ----------------------------------------------------------
  task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task automatic cyc(input int c);
    repeat (c) @(negedge clock);
  endtask
  // waits for both path switches off, then counts the off cycles
  task automatic handover(output int wt, output int offc);
    offc = 0;
    for (wt = 0; wt < 80 && (adapterDrv | batteryDrv) !== 1'b0; wt++)
      cyc(1);
    while (offc < 80 && (adapterDrv | batteryDrv) === 1'b0) begin
      offc++;
      cyc(1);
    end
  endtask
  task automatic waitCharge(input logic v);
    for (int n = 0; n < 80 && charging !== v; n++) cyc(1);
  endtask
  task automatic complete_run;
    if (err_total == 0 && check_count > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  initial begin
    #(6000 * 50);
    err_total++;
    complete_run();
  end

  // ----------------------------------------------------------
  // tests
  // ----------------------------------------------------------
  initial begin
    repeat (20) @(posedge clock);
    reset <= 1'b0;
    cyc(1);
    chk(batteryDrv, 1);
    chk(adapterDrv, 0);
    chk(sleeping, 1);
    // adapter plugged with every charge condition good
    @(posedge clock);
    cfg.regsGood <= 1'b1;
    cfg.tempBelowFall <= 1'b1;
    chargeEnable <= 1'b1;
    pwmRequest <= 1'b1;
    senseAboveSync <= 1'b1;
    supplyMv <= 16'h4e20;
    cyc(3);
    chk(sleeping, 0);
    chk(batteryDrv, 1);
    handover(t, off);
    chk(t + 3 >= SLX - 2 && t + 3 <= SLX + 5, 1);
    chk(off >= DEAD && off <= DEAD + 3, 1);
    chk(adapterDrv, 1);
    // soft-start steps on fast-charge entry
    for (i = 0; i < 10 && chargeRef !== 4'h1; i++) cyc(1);
    chk(charging, 1);
    for (s = 1; s <= 8; s++) begin
      repeat (STEP) begin
        chk(chargeRef, s[7:0]);
        cyc(1);
      end
    end
    chk(chargeRef, 8);
    // switching mode table
    for (i = 0; i < 4; i++) begin
      @(posedge clock);
      {senseAboveSync, batteryBelow2V, senseAvgLow} <= MODE_IN[i];
      cyc(3);
      chk(convMode, i == 0 ? cps_pkg::ModeSync : cps_pkg::ModeNonSync);
    end
    // refresh pulses while non-synchronous at full request
    @(posedge clock);
    lowMax = 0;
    lowPulses = 0;
    cyc(100);
    chk(lowPulses > 0, 1);
    chk(lowMax, 2);
    // zero duty: no high side, refresh pulse only
    @(posedge clock);
    pwmRequest <= 1'b0;
    cyc(2);
    highCnt = 0;
    lowMax = 0;
    cyc(60);
    chk(highCnt, 0);
    chk(lowMax <= 2, 1);
    @(posedge clock);
    pwmRequest <= 1'b1;
    // five stop conditions (low supply, input overvoltage, undervoltage, overload, thermistor), each then recovery with a fresh soft-start
    for (i = 0; i < 5; i++) begin
      @(posedge clock);
      cfg <= cfg ^ FAULT[i];
      cyc(3);
      chk(charging, 0);
      @(posedge clock);
      cfg <= cfg ^ FAULT[i];
      waitCharge(1'b1);
      chk(charging, 1);
      chk(chargeRef <= 1, 1);
    end
    // overtemp holds through the hysteresis band
    @(posedge clock);
    cfg.tempAboveRise <= 1'b1;
    cfg.tempBelowFall <= 1'b0;
    cyc(3);
    chk(charging, 0);
    @(posedge clock);
    cfg.tempAboveRise <= 1'b0;
    cyc(10);
    chk(charging, 0);
    @(posedge clock);
    cfg.tempBelowFall <= 1'b1;
    waitCharge(1'b1);
    chk(charging, 1);
    // enable low stops, then regulators not good hold charge off after re-enable
    @(posedge clock);
    chargeEnable <= 1'b0;
    cyc(3);
    chk(charging, 0);
    @(posedge clock);
    chargeEnable <= 1'b1;
    cfg.regsGood <= 1'b0;
    cyc(5);
    chk(charging, 0);
    cyc(30);
    chk(charging, 0);
    @(posedge clock);
    cfg.regsGood <= 1'b1;
    waitCharge(1'b1);
    chk(charging, 1);
    // safety expiry latches until enable toggles
    @(posedge clock);
    cfg.safetyExpired <= 1'b1;
    @(posedge clock);
    cfg.safetyExpired <= 1'b0;
    cyc(10);
    chk(charging, 0);
    @(posedge clock);
    chargeEnable <= 1'b0;
    cyc(2);
    @(posedge clock);
    chargeEnable <= 1'b1;
    waitCharge(1'b1);
    chk(charging, 1);
    // lockout: adapter off, battery on
    @(posedge clock);
    cfg.underVoltage <= 1'b1;
    cyc(DEAD + 6);
    chk({adapterDrv, batteryDrv, charging}, 3'h2);
    @(posedge clock);
    cfg.underVoltage <= 1'b0;
    for (i = 0; i < 80 && adapterDrv !== 1'b1; i++) cyc(1);
    chk(adapterDrv, 1);
    // adapter removed: hold until supply near battery
    @(posedge clock);
    supplyMv <= 16'h30d4;
    cyc(10);
    chk(adapterDrv, 1);
    @(posedge clock);
    supplyMv <= 16'h2f44;
    handover(t, off);
    chk(off >= DEAD && off <= DEAD + 3, 1);
    chk(batteryDrv, 1);
    @(posedge clock);
    supplyMv <= 16'h2af8;
    cyc(5);
    chk({sleeping, batteryDrv, adapterDrv}, 3'h6);
    chk(shoot, 0);
    complete_run();
  end
endmodule
